// ---- rtl/ovh_port_pkg.sv ----
package ovh_port_pkg;

    // width of one overhead byte as it leaves the receive framer
    localparam int BYTE_W = 8;
    // bit counter width inside the serializer
    localparam int BIT_CNT_W = $clog2(BYTE_W);
    // system clock period in ns (40 MHz)
    localparam int SYS_CLK_NS = 25;
    // chosen period of the generated port clock in ns
    localparam int PORT_CLK_NS = 50;
    // half period in system cycles, rounded up; zero when PORT_CLK_NS is below two
    localparam int PORT_HALF_CYC =
        ((PORT_CLK_NS / 2) + SYS_CLK_NS - 1) / SYS_CLK_NS;
    // port clock periods for which the frame marker stands high
    localparam int MARKER_PERIODS = 8;
    // reset values of the output pins
    localparam logic RST_PORT_CLK = 1'b0;
    localparam logic RST_SERIAL = 1'b0;
    localparam logic RST_VALID = 1'b0;
    localparam logic RST_MARKER = 1'b0;
    localparam logic RST_READY = 1'b0;

    // line side hand-off states
    typedef enum logic {
        LINK_READY = 1'b0,
        LINK_WAIT = 1'b1
    } link_state_t;

    // serializer states
    typedef enum logic {
        SER_IDLE = 1'b0,
        SER_SHIFT = 1'b1
    } ser_state_t;

endpackage : ovh_port_pkg

// ---- rtl/bit_sync2.sv ----
`timescale 1ns/1ps
// two-stage level synchroniser, reset to a constant
module bit_sync2 (
    input wire logic clk_in, // destination clock
    input wire logic reset_n_in, // async reset, active low
    input wire logic d_in, // level from another domain
    output logic q_out // synchronised level
);
    logic meta; // first stage, read only by the second
    logic next_meta; // next first stage
    logic next_q; // next second stage

    // next values: plain shift
    always_comb begin
        next_meta = d_in;
        next_q = meta;
    end

    // both stages clear to zero under reset
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta <= next_meta;
            q_out <= next_q;
        end
    end
endmodule : bit_sync2

// ---- rtl/port_clk_gen.sv ----
`timescale 1ns/1ps
// divides the system clock into the overhead port clock
module port_clk_gen #(
    parameter int HALF_CYCLES = 1 // system cycles per half period
) (
    input wire logic clk_in, // system clock
    input wire logic reset_n_in, // async reset, active low
    output logic port_clk_out, // divided clock level, from a flop
    output logic fall_tick_out // high in the cycle before a fall
);
    localparam int CNT_W = $clog2(HALF_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYCLES - 1);

    generate
        if (HALF_CYCLES < 1) begin : g_bad_half
            $error("port_clk_gen: HALF_CYCLES must be at least 1");
        end
    endgenerate

    logic [CNT_W-1:0] cnt; // cycles spent in the current half
    logic [CNT_W-1:0] next_cnt; // next half counter
    logic next_port_clk; // next clock level

    // the flop below toggles when this is high and clock is high
    assign fall_tick_out = port_clk_out && (cnt == CNT_LAST);

    // toggle the clock level at the end of each half period
    always_comb begin
        next_cnt = cnt + CNT_W'(1);
        next_port_clk = port_clk_out;
        if (cnt == CNT_LAST) begin
            next_cnt = '0;
            next_port_clk = ~port_clk_out;
        end
    end

    // clock starts low so the first edge seen outside is rising
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt <= '0;
            port_clk_out <= 1'b0;
        end else begin
            cnt <= next_cnt;
            port_clk_out <= next_port_clk;
        end
    end
endmodule : port_clk_gen

// ---- rtl/ovh_serial_port.sv ----
`timescale 1ns/1ps
module ovh_serial_port
    import ovh_port_pkg::*;
#(
    parameter int PORT_HALF_CYCLES = ovh_port_pkg::PORT_HALF_CYC
) (
    input wire logic CLK_SYS_IN, // system clock, 40 MHz
    input wire logic RESET_N_IN, // async reset, active low
    input wire logic LINE_CLK_IN, // receive line byte clock
    input wire logic [ovh_port_pkg::BYTE_W-1:0] TOH_BYTE_IN, // oh byte
    input wire logic TOH_VALID_IN, // oh byte offered
    input wire logic TOH_A1_IN, // offered byte is the A1 byte
    output logic TOH_READY_OUT, // byte taken when valid and ready
    output logic OVH_PORT_CLOCK_OUT, // ovh_port_clock pin
    output logic OVH_SERIAL_OUT, // ovh_serial_out pin
    output logic OVH_BIT_VALID_OUT, // ovh_bit_valid pin
    output logic OVH_FRAME_MARKER_OUT // ovh_frame_marker pin
);
    import ovh_port_pkg::*;

    // refuse settings the serializer cannot honour
    generate
        if (PORT_HALF_CYCLES < 1) begin : g_bad_half
            $error("ovh_serial_port: PORT_HALF_CYCLES below 1");
        end
        if (BYTE_W != MARKER_PERIODS) begin : g_bad_marker
            $error("ovh_serial_port: marker must span one byte");
        end
    endgenerate

    localparam logic [BIT_CNT_W-1:0] BIT_LAST = BIT_CNT_W'(BYTE_W - 1);

    // ------------------------------------------------------------
    // line clock domain
    // ------------------------------------------------------------

    logic line_rst_n; // reset released in step with the line clock
    logic ack_tgl; // consume toggle, system domain
    logic ack_tgl_line; // consume toggle seen on the line clock

    // reset release is synchronised so the line flops leave reset
    // together; assertion still acts at once
    bit_sync2 u_line_rst (
        .clk_in(LINE_CLK_IN),
        .reset_n_in(RESET_N_IN),
        .d_in(1'b1),
        .q_out(line_rst_n)
    );

    // bring the consume toggle over into the line domain
    bit_sync2 u_ack_sync (
        .clk_in(LINE_CLK_IN),
        .reset_n_in(line_rst_n),
        .d_in(ack_tgl),
        .q_out(ack_tgl_line)
    );

    link_state_t link_state; // hand-off state
    link_state_t next_link_state; // next hand-off state
    logic req_tgl; // toggles once per byte handed over
    logic next_req_tgl; // next request toggle
    logic [BYTE_W-1:0] hold_byte; // byte held steady for crossing
    logic [BYTE_W-1:0] next_hold_byte; // next held byte
    logic hold_a1; // held byte is the A1 byte
    logic next_hold_a1; // next A1 tag
    logic next_ready; // next value of the ready pin

    // one byte in flight at a time: the held byte stays still from
    // the request toggle until the consume toggle comes back, so
    // the system side may read it as a quiet multi-bit word
    always_comb begin
        next_link_state = link_state;
        next_req_tgl = req_tgl;
        next_hold_byte = hold_byte;
        next_hold_a1 = hold_a1;
        next_ready = TOH_READY_OUT;
        case (link_state)
            LINK_READY: begin
                // take the offered byte and raise the request
                if (TOH_VALID_IN && TOH_READY_OUT) begin
                    next_hold_byte = TOH_BYTE_IN;
                    next_hold_a1 = TOH_A1_IN;
                    next_req_tgl = ~req_tgl;
                    next_ready = 1'b0;
                    next_link_state = LINK_WAIT;
                end else begin
                    next_ready = 1'b1;
                end
            end
            LINK_WAIT: begin
                // byte consumed once both toggles agree again
                if (ack_tgl_line == req_tgl) begin
                    next_ready = 1'b1;
                    next_link_state = LINK_READY;
                end
            end
            default: begin
                // unreachable code, recover to the safe state
                next_ready = 1'b0;
                next_link_state = LINK_READY;
            end
        endcase
    end

    // line domain registers
    always_ff @(posedge LINE_CLK_IN or negedge line_rst_n) begin
        if (!line_rst_n) begin
            link_state <= LINK_READY;
            req_tgl <= 1'b0;
            hold_byte <= '0;
            hold_a1 <= 1'b0;
            TOH_READY_OUT <= RST_READY;
        end else begin
            link_state <= next_link_state;
            req_tgl <= next_req_tgl;
            hold_byte <= next_hold_byte;
            hold_a1 <= next_hold_a1;
            TOH_READY_OUT <= next_ready;
        end
    end

    // ------------------------------------------------------------
    // system clock domain
    // ------------------------------------------------------------

    logic req_tgl_sys; // request toggle seen on the system clock
    logic fall_tick; // the port clock falls at the coming edge

    // bring the request toggle over into the system domain
    bit_sync2 u_req_sync (
        .clk_in(CLK_SYS_IN),
        .reset_n_in(RESET_N_IN),
        .d_in(req_tgl),
        .q_out(req_tgl_sys)
    );

    // the port clock is made here and driven out, so the far side
    // takes its sampling clock from us and not the other way round
    port_clk_gen #(
        .HALF_CYCLES(PORT_HALF_CYCLES)
    ) u_clk_gen (
        .clk_in(CLK_SYS_IN),
        .reset_n_in(RESET_N_IN),
        .port_clk_out(OVH_PORT_CLOCK_OUT),
        .fall_tick_out(fall_tick)
    );

    // pending byte, filled from the crossing
    logic req_seen; // request toggle already taken
    logic next_req_seen; // next taken toggle
    logic new_req; // a fresh byte waits in the held register
    logic pend_full; // pending register holds a byte
    logic next_pend_full; // next pending flag
    logic [BYTE_W-1:0] pend_byte; // byte waiting for the shifter
    logic [BYTE_W-1:0] next_pend_byte; // next pending byte
    logic pend_a1; // pending byte is the A1 byte
    logic next_pend_a1; // next pending A1 tag

    // serializer
    ser_state_t ser_state; // idle or shifting
    ser_state_t next_ser_state; // next serializer state
    logic [BYTE_W-1:0] shreg; // bits still to go, msb next
    logic [BYTE_W-1:0] next_shreg; // next shift register
    logic [BIT_CNT_W-1:0] bit_cnt; // bits of this byte still to go
    logic [BIT_CNT_W-1:0] next_bit_cnt; // next bit count
    logic cur_a1; // byte on the pin is the A1 byte
    logic next_cur_a1; // next A1 tag of the shifting byte
    logic next_ack_tgl; // next consume toggle
    logic next_serial; // next data pin value
    logic next_valid; // next valid pin value
    logic next_marker; // next marker pin value
    logic load; // pending byte moves into the shifter

    assign new_req = (req_tgl_sys != req_seen);

    // a fresh load is due at a fall when the last bit is out
    assign load = fall_tick && pend_full &&
        ((ser_state == SER_IDLE) || (bit_cnt == '0));

    // pending register: the fill wins over the clear, though the
    // line side cannot offer a byte before the clear is acked
    always_comb begin
        next_req_seen = req_tgl_sys;
        next_pend_full = pend_full;
        next_pend_byte = pend_byte;
        next_pend_a1 = pend_a1;
        if (load) begin
            next_pend_full = 1'b0;
        end
        if (new_req) begin
            next_pend_full = 1'b1;
            next_pend_byte = hold_byte;
            next_pend_a1 = hold_a1;
        end
    end

    // data, valid and marker pins move only at the system edge where the port
    // clock goes low; between falls each of these three holds its value
    always_comb begin
        next_ser_state = ser_state;
        next_shreg = shreg;
        next_bit_cnt = bit_cnt;
        next_cur_a1 = cur_a1;
        next_ack_tgl = ack_tgl;
        next_serial = OVH_SERIAL_OUT;
        next_valid = OVH_BIT_VALID_OUT;
        next_marker = OVH_FRAME_MARKER_OUT;
        if (fall_tick) begin
            case (ser_state)
                SER_IDLE: begin
                    // nothing on the pin unless a byte is loaded
                    next_serial = 1'b0;
                    next_valid = 1'b0;
                    next_marker = 1'b0;
                end
                SER_SHIFT: begin
                    if (bit_cnt != '0) begin
                        // next bit of the byte, msb first
                        next_serial = shreg[BYTE_W-1];
                        next_shreg = {shreg[BYTE_W-2:0], 1'b0};
                        next_bit_cnt = bit_cnt - BIT_CNT_W'(1);
                        next_valid = 1'b1;
                        next_marker = cur_a1;
                    end else begin
                        // byte done and none waiting: go quiet
                        next_serial = 1'b0;
                        next_valid = 1'b0;
                        next_marker = 1'b0;
                        next_ser_state = SER_IDLE;
                    end
                end
                default: begin
                    // unreachable code, drop back to idle
                    next_serial = 1'b0;
                    next_valid = 1'b0;
                    next_marker = 1'b0;
                    next_ser_state = SER_IDLE;
                end
            endcase
            if (load) begin
                // first bit of the new byte goes out at once, so
                // bytes follow back to back with no dead period
                next_serial = pend_byte[BYTE_W-1];
                next_shreg = {pend_byte[BYTE_W-2:0], 1'b0};
                next_bit_cnt = BIT_LAST;
                next_cur_a1 = pend_a1;
                next_valid = 1'b1;
                next_marker = pend_a1;
                next_ack_tgl = ~ack_tgl;
                next_ser_state = SER_SHIFT;
            end
        end
    end

    // system domain registers; the pins come straight from here
    // and the far side samples them on the rising edge
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            req_seen <= 1'b0;
            pend_full <= 1'b0;
            pend_byte <= '0;
            pend_a1 <= 1'b0;
            ser_state <= SER_IDLE;
            shreg <= '0;
            bit_cnt <= '0;
            cur_a1 <= 1'b0;
            ack_tgl <= 1'b0;
            OVH_SERIAL_OUT <= RST_SERIAL;
            OVH_BIT_VALID_OUT <= RST_VALID;
            OVH_FRAME_MARKER_OUT <= RST_MARKER;
        end else begin
            req_seen <= next_req_seen;
            pend_full <= next_pend_full;
            pend_byte <= next_pend_byte;
            pend_a1 <= next_pend_a1;
            ser_state <= next_ser_state;
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
            cur_a1 <= next_cur_a1;
            ack_tgl <= next_ack_tgl;
            OVH_SERIAL_OUT <= next_serial;
            OVH_BIT_VALID_OUT <= next_valid;
            OVH_FRAME_MARKER_OUT <= next_marker;
        end
    end

endmodule : ovh_serial_port

// ---- sim/ovh_port_properties.sv ----
`timescale 1ns/1ps
// watches the serial overhead pins of the port from the outside
module ovh_port_properties #(
    parameter int PORT_HALF_CYCLES = 1 // system cycles per half period
) (
    input wire logic CLK_SYS_IN, // system clock
    input wire logic RESET_N_IN, // async reset, active low
    input wire logic LINE_CLK_IN, // line byte clock
    input wire logic TOH_VALID_IN, // byte offered
    input wire logic TOH_READY_OUT, // byte can be taken
    input wire logic OVH_PORT_CLOCK_OUT, // generated port clock
    input wire logic OVH_SERIAL_OUT, // serial data
    input wire logic OVH_BIT_VALID_OUT, // bit valid strobe
    input wire logic OVH_FRAME_MARKER_OUT // frame marker
);
    // two clock domains watched here, so every property names its own
    // clock and reset instead of sharing a default

    logic prev_clk; // port clock one system cycle ago
    logic [7:0] run_len; // cycles the port clock stood still
    logic [7:0] mark_len; // cycles the marker has stood high
    logic [7:0] valid_len; // cycles valid has stood high

    // run lengths; small widths are enough for the short half periods
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            prev_clk <= 1'b0;
            run_len <= 8'h00;
            mark_len <= 8'h00;
            valid_len <= 8'h00;
        end else begin
            prev_clk <= OVH_PORT_CLOCK_OUT;
            run_len <= (OVH_PORT_CLOCK_OUT == prev_clk) ?
                run_len + 8'h01 : 8'h00;
            mark_len <= OVH_FRAME_MARKER_OUT ? mark_len + 8'h01 : 8'h00;
            valid_len <= OVH_BIT_VALID_OUT ? valid_len + 8'h01 : 8'h00;
        end
    end

    // the only moment at which the data, valid and marker outputs may move
    sequence port_fall;
        $fell(OVH_PORT_CLOCK_OUT);
    endsequence

    sequence marker_end;
        $fell(OVH_FRAME_MARKER_OUT);
    endsequence

    chk_data_on_fall: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        $changed(OVH_SERIAL_OUT) |-> port_fall)
        else $error("serial data moved off a port clock fall");
    chk_valid_on_fall: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        $changed(OVH_BIT_VALID_OUT) |-> port_fall)
        else $error("bit valid moved off a port clock fall");
    chk_marker_on_fall: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        $changed(OVH_FRAME_MARKER_OUT) |-> port_fall)
        else $error("frame marker moved off a port clock fall");
    chk_marker_with_valid: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        OVH_FRAME_MARKER_OUT |-> OVH_BIT_VALID_OUT)
        else $error("frame marker high without a valid bit");
    chk_marker_eight_periods: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        marker_end |-> mark_len == 16 * PORT_HALF_CYCLES)
        else $error("frame marker not high for eight periods");
    chk_valid_whole_bytes: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        $fell(OVH_BIT_VALID_OUT) |->
            valid_len % (16 * PORT_HALF_CYCLES) == 0)
        else $error("bit valid run is not whole bytes");
    chk_idle_data_low: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        !OVH_BIT_VALID_OUT |-> !OVH_SERIAL_OUT)
        else $error("serial data high while no bit is valid");
    chk_clock_keeps_toggling: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        run_len <= PORT_HALF_CYCLES)
        else $error("port clock stood still too long");
    chk_ready_drops: assert property (
        @(posedge LINE_CLK_IN) disable iff (!RESET_N_IN)
        TOH_VALID_IN && TOH_READY_OUT
            |=> !TOH_READY_OUT)
        else $error("ready stayed high after a byte was taken");
endmodule : ovh_port_properties

bind ovh_serial_port ovh_port_properties #(
    .PORT_HALF_CYCLES(PORT_HALF_CYCLES)
) chk_u (
    .CLK_SYS_IN(CLK_SYS_IN),
    .RESET_N_IN(RESET_N_IN),
    .LINE_CLK_IN(LINE_CLK_IN),
    .TOH_VALID_IN(TOH_VALID_IN),
    .TOH_READY_OUT(TOH_READY_OUT),
    .OVH_PORT_CLOCK_OUT(OVH_PORT_CLOCK_OUT),
    .OVH_SERIAL_OUT(OVH_SERIAL_OUT),
    .OVH_BIT_VALID_OUT(OVH_BIT_VALID_OUT),
    .OVH_FRAME_MARKER_OUT(OVH_FRAME_MARKER_OUT)
);

// ---- sim/ovh_collector.sv ----
`timescale 1ns/1ps
// user logic that collects overhead bytes from the serial port
module ovh_collector (
    input wire logic reset_n_in, // async reset, active low
    input wire logic port_clk_in, // port clock from the device
    input wire logic data_in, // serial data
    input wire logic valid_in, // bit valid strobe
    input wire logic marker_in, // frame marker
    output logic [7:0] byte_out, // last complete byte
    output logic [7:0] marks_out, // marker seen on each of its bits
    output logic [15:0] count_out // bytes collected so far
);
    logic [7:0] shift; // bits gathered, first bit ends up on top
    logic [7:0] mshift; // marker bits gathered alongside
    logic [2:0] bit_cnt; // position inside the byte

    // sample on the rise only: data has had half a period to settle
    always @(posedge port_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shift <= 8'h00;
            mshift <= 8'h00;
            bit_cnt <= 3'h0;
            byte_out <= 8'h00;
            marks_out <= 8'h00;
            count_out <= 16'h0000;
        end else if (valid_in) begin
            shift <= {shift[6:0], data_in};
            mshift <= {mshift[6:0], marker_in};
            bit_cnt <= bit_cnt + 3'h1;
            // eighth bit closes the byte
            if (bit_cnt == 3'h7) begin
                byte_out <= {shift[6:0], data_in};
                marks_out <= {mshift[6:0], marker_in};
                count_out <= count_out + 16'h0001;
            end
        end
    end
endmodule : ovh_collector

// ---- sim/receive_overhead_serial_port_bench.sv ----
`timescale 1ns/1ps
// drives overhead bytes in and judges what the serial port gives out
module receive_overhead_serial_port_bench;
    import ovh_port_pkg::*;
    localparam int HALF = 1; // port clock half period in system cycles
    logic clk_sys = 1'b0; // system clock
    logic line_clk = 1'b0; // line byte clock
    logic reset_n; // reset, active low, unknown until first driven
    logic [7:0] toh_byte = 8'h00; // offered byte
    logic toh_valid = 1'b0; // byte offered
    logic toh_a1 = 1'b0; // offered byte is the A1 byte
    logic toh_ready, port_clk, ser_data, bit_valid, frame_marker;
    logic [7:0] got_byte, got_marks; // from the collector
    logic [15:0] got_count; // bytes collected
    int err_total = 0; // mismatches
    int samples_checked = 0; // comparisons made

    always #12.5 clk_sys = ~clk_sys;
    // line clock starts off phase with the system clock
    initial begin
        #3.3;
        forever #7.5 line_clk = ~line_clk;
    end

    ovh_serial_port #(.PORT_HALF_CYCLES(HALF)) dut_u (
        .CLK_SYS_IN(clk_sys), .RESET_N_IN(reset_n),
        .LINE_CLK_IN(line_clk), .TOH_BYTE_IN(toh_byte),
        .TOH_VALID_IN(toh_valid), .TOH_A1_IN(toh_a1),
        .TOH_READY_OUT(toh_ready), .OVH_PORT_CLOCK_OUT(port_clk),
        .OVH_SERIAL_OUT(ser_data), .OVH_BIT_VALID_OUT(bit_valid),
        .OVH_FRAME_MARKER_OUT(frame_marker)
    );

    ovh_collector model_u (
        .reset_n_in(reset_n), .port_clk_in(port_clk), .data_in(ser_data),
        .valid_in(bit_valid), .marker_in(frame_marker),
        .byte_out(got_byte), .marks_out(got_marks), .count_out(got_count)
    );

    task check(input string what, input logic [15:0] seen,
               input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // offer a byte and hold it until an edge sees ready high
    task send_byte(input logic [7:0] b, input logic a1);
        int n;
        @(posedge line_clk);
        toh_byte <= b;
        toh_valid <= 1'b1;
        toh_a1 <= a1;
        n = 0;
        do begin
            @(posedge line_clk);
            n++;
        end while (toh_ready !== 1'b1 && n < 200);
        if (n >= 200) check("ready wait", 16'h0000, 16'h0001);
        // released lines show garbage, not the old byte
        toh_valid <= 1'b0;
        toh_byte <= ~b;
        toh_a1 <= ~a1;
    endtask : send_byte

    // bounded wait for the collector to reach a byte count
    task wait_count(input int n);
        int k;
        k = 0;
        while (got_count < n && k < 2000) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 2000) check("byte wait", got_count, n[15:0]);
    endtask : wait_count

    // A1 byte right before an ordinary one: marker must not bleed over
    task t_a1_then_plain;
        fork
            begin
                send_byte(8'ha5, 1'b1);
                send_byte(8'h5a, 1'b0);
            end
            begin
                wait_count(1);
                check("a1 byte", {8'h00, got_byte}, 16'h00a5);
                check("a1 marks", {8'h00, got_marks}, 16'h00ff);
                wait_count(2);
                check("plain byte", {8'h00, got_byte}, 16'h005a);
                check("plain marks", {8'h00, got_marks}, 16'h0);
            end
        join
    endtask : t_a1_then_plain

    // back-to-back boundary patterns
    task t_back_to_back;
        logic [7:0] pat [3];
        pat = '{8'h00, 8'hff, 8'h81};
        fork
            for (int i = 0; i < 3; i++) send_byte(pat[i], 1'b0);
            for (int j = 0; j < 3; j++) begin
                wait_count(3 + j);
                check("stream byte", {8'h00, got_byte}, {8'h00, pat[j]});
            end
        join
    endtask : t_back_to_back

    // nothing pending: valid and data low, port clock still running
    task t_idle;
        int bad, toggles;
        logic prev;
        bad = 0;
        toggles = 0;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        prev = port_clk;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk_sys);
            if (bit_valid !== 1'b0 || ser_data !== 1'b0) bad++;
            if (port_clk !== prev) toggles++;
            prev = port_clk;
        end
        check("idle bits", bad[15:0], 16'h0000);
        check("clock toggles", toggles[15:0], 16'(40 / HALF));
    endtask : t_idle

    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // main sequence
    initial begin
        // a step from unknown to low is a falling edge, so every async
        // reset fires at once; the collector sees no port clock rise
        // during reset and would otherwise keep unknown counters
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("reset pins", {12'h000, port_clk, ser_data, bit_valid,
            frame_marker}, 16'h0000);
        reset_n <= 1'b1;
        t_a1_then_plain();
        t_back_to_back();
        t_idle();
        end_sim();
    end

    // the tests take a few microseconds; this cuts a hang short
    initial begin
        #100us;
        err_total++;
        end_sim();
    end
endmodule : receive_overhead_serial_port_bench
